/* shared/swm_pkg.sv */
// constants, types and timing for the single-wire master configuration block
package swm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and counter sizing
	localparam int CLK_PERIOD_NS = 100;  // 10 MHz system clock
	localparam int CNT_W         = 16;   // interval counter width
	localparam int NIB_W         = 4;    // configuration nibble width
	localparam int BYTE_W        = 8;

	// least time in ns to whole cycles, never below one cycle
	function automatic int cyc_least(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus timing in ns (standard / overdrive), plain defaults
	localparam int RESET_LOW_STD_NS   = 480000;  // reset_low_time
	localparam int RESET_HIGH_STD_NS  = 480000;  // release to end of reset
	localparam int RESET_LOW_OD_NS    = 48000;
	localparam int RESET_HIGH_OD_NS   = 48000;
	localparam int MASK_START_NS      = 2000;    // mask_start_time
	localparam int MASK_END_NS        = 8000;    // mask_end_time
	localparam int SHORT_STD_NS       = 9000;    // short_sample_time
	localparam int SHORT_OD_NS        = 1000;
	localparam int PRES_STD_NS        = 70000;   // presence_sample_time
	localparam int PRES_OD_NS         = 8500;
	localparam int SLOT_STD_NS        = 65000;   // whole standard slot
	localparam int SLOT_OD_NS         = 10000;
	localparam int W1_LOW_STD_NS      = 6000;
	localparam int W1_LOW_OD_NS       = 1000;
	localparam int W0_LOW_STD_NS      = 60000;
	localparam int W0_LOW_OD_NS       = 7500;
	localparam int SAMPLE_STD_NS      = 15000;   // sample point in slot
	localparam int SAMPLE_OD_NS       = 2000;
	localparam int APU_ON_NS          = 2500;    // active_pullup_on_time

	////////////////////////////////////////////////////////////////////////////
	// derived cycle counts, all below the counter range
	localparam logic [CNT_W-1:0] RLOW_OD_CYC =
		CNT_W'(cyc_least(RESET_LOW_OD_NS));
	localparam logic [CNT_W-1:0] RHIGH_OD_CYC =
		CNT_W'(cyc_least(RESET_HIGH_OD_NS - PRES_OD_NS));
	localparam logic [CNT_W-1:0] MASK_START_CYC =
		CNT_W'(cyc_least(MASK_START_NS));
	localparam logic [CNT_W-1:0] MASK_LEN_CYC =
		CNT_W'(cyc_least(MASK_END_NS - MASK_START_NS));
	localparam logic [CNT_W-1:0] SHORT_AFTER_MASK_CYC =
		CNT_W'(cyc_least(SHORT_STD_NS - MASK_END_NS));
	localparam logic [CNT_W-1:0] SHORT_STD_CYC =
		CNT_W'(cyc_least(SHORT_STD_NS));
	localparam logic [CNT_W-1:0] SHORT_OD_CYC =
		CNT_W'(cyc_least(SHORT_OD_NS));
	localparam logic [CNT_W-1:0] PRES_STD_CYC =
		CNT_W'(cyc_least(PRES_STD_NS - SHORT_STD_NS));
	localparam logic [CNT_W-1:0] PRES_OD_CYC =
		CNT_W'(cyc_least(PRES_OD_NS - SHORT_OD_NS));
	localparam logic [CNT_W-1:0] W1_LOW_STD_CYC =
		CNT_W'(cyc_least(W1_LOW_STD_NS));
	localparam logic [CNT_W-1:0] W1_LOW_OD_CYC =
		CNT_W'(cyc_least(W1_LOW_OD_NS));
	localparam logic [CNT_W-1:0] W0_LOW_STD_CYC =
		CNT_W'(cyc_least(W0_LOW_STD_NS));
	localparam logic [CNT_W-1:0] W0_LOW_OD_CYC =
		CNT_W'(cyc_least(W0_LOW_OD_NS));
	localparam logic [CNT_W-1:0] SAMP_STD_CYC =
		CNT_W'(cyc_least(SAMPLE_STD_NS - W1_LOW_STD_NS));
	localparam logic [CNT_W-1:0] SAMP_OD_CYC =
		CNT_W'(cyc_least(SAMPLE_OD_NS - W1_LOW_OD_NS));
	localparam logic [CNT_W-1:0] REST1_STD_CYC =
		CNT_W'(cyc_least(SLOT_STD_NS - SAMPLE_STD_NS));
	localparam logic [CNT_W-1:0] REST1_OD_CYC =
		CNT_W'(cyc_least(SLOT_OD_NS - SAMPLE_OD_NS));
	localparam logic [CNT_W-1:0] REST0_STD_CYC =
		CNT_W'(cyc_least(SLOT_STD_NS - W0_LOW_STD_NS));
	localparam logic [CNT_W-1:0] REST0_OD_CYC =
		CNT_W'(cyc_least(SLOT_OD_NS - W0_LOW_OD_NS));
	localparam logic [CNT_W-1:0] SAMP0_CYC    = CNT_W'(1);
	localparam logic [CNT_W-1:0] APU_ON_CYC   = CNT_W'(cyc_least(APU_ON_NS));

	////////////////////////////////////////////////////////////////////////////
	// read pointer codes and command set
	localparam logic [7:0] PTR_CODE_STATUS = 8'hf0;
	localparam logic [7:0] PTR_CODE_DATA   = 8'he1;
	localparam logic [7:0] PTR_CODE_CONFIG = 8'hc3;
	localparam int         LAST_BIT        = 7;

	typedef enum logic [2:0] {
		OP_DEV_RESET   = 3'h0,
		OP_WRITE_CFG   = 3'h1,
		OP_SET_PTR     = 3'h2,
		OP_BUS_RESET   = 3'h3,
		OP_SINGLE_BIT  = 3'h4,
		OP_WRITE_BYTE  = 3'h5
	} op_t;

	typedef enum logic [1:0] {
		PTR_STATUS = 2'h0,
		PTR_DATA   = 2'h1,
		PTR_CONFIG = 2'h2
	} ptr_t;

	typedef struct packed {
		op_t        op;     // decoded function command
		logic [7:0] param;  // parameter byte
	} cmd_t;

	// lower configuration nibble, bit 3 down to bit 0
	typedef struct packed {
		logic overdrive_select;
		logic strong_pullup_enable;
		logic presence_mask_enable;
		logic active_pullup_enable;
	} cfg_t;

	// status register, bit 7 down to bit 0
	typedef struct packed {
		logic branch_direction;
		logic triplet_second_bit;
		logic single_bit_result;
		logic reset_occurred_flag;
		logic line_level;
		logic short_detect;
		logic presence_detect_flag;
		logic line_busy_flag;
	} status_t;

	localparam cfg_t    CFG_RESET  = '0;
	localparam status_t STAT_RESET = '{reset_occurred_flag: 1'b1,
		default: 1'b0};

endpackage

/* design/interval_timer.sv */
// reloadable down counter that times one bus phase
`timescale 1ns/10ps
module interval_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,      // start a new interval
	input  wire logic [WIDTH-1:0] load_val,  // interval length in cycles
	output logic                  done,      // last cycle of interval
	output logic                  running    // interval in progress
);

	logic [WIDTH-1:0] cnt_reg;  // cycles left
	logic [WIDTH-1:0] cnt_next;

	////////////////////////////////////////////////////////////////////////////
	// a load wins over the running count so phases chain without a gap
	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = load_val;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - WIDTH'(1);
		end
	end

	// register only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign done    = (cnt_reg == WIDTH'(1));
	assign running = (cnt_reg != '0);

endmodule

/* design/single_wire_master_config_status.sv */
// configuration, status and bus timing of the single-wire master
`timescale 1ns/10ps
module single_wire_master_config_status #(
	parameter int RESET_LOW_CYC  =
		swm_pkg::cyc_least(swm_pkg::RESET_LOW_STD_NS),
	parameter int RESET_HIGH_CYC =
		swm_pkg::cyc_least(swm_pkg::RESET_HIGH_STD_NS - swm_pkg::PRES_STD_NS)
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          cmd_valid,          // command strobe
	input  wire swm_pkg::cmd_t cmd,                // command and parameter
	output logic               cmd_ack,            // command taken
	output logic               cmd_nack,           // command refused
	input  wire logic          rd_strobe,          // host reads a byte
	output logic [7:0]         rd_data,            // selected register
	input  wire logic          io_in,              // bus line level
	output logic               io_out,             // bus drive value
	output logic               io_oe,              // pulldown active
	output logic               pullup_drive,       // pullup transistor on
	output logic               mask_slew_limit,    // slow falling edge
	output logic               ext_pullup_ctrl_n   // external mosfet, low on
);

	////////////////////////////////////////////////////////////////////////////
	// parameter checks
	if (RESET_LOW_CYC < 1 || RESET_LOW_CYC >= (1 << swm_pkg::CNT_W) ||
		RESET_HIGH_CYC < 1 || RESET_HIGH_CYC >= (1 << swm_pkg::CNT_W)) begin
		$error("reset counts do not fit the interval counter");
	end

	////////////////////////////////////////////////////////////////////////////
	// state and storage
	typedef enum logic [9:0] {
		S_IDLE  = 10'h001,  // no bus activity
		S_RLOW  = 10'h002,  // reset low pulse
		S_RWAIT = 10'h004,  // wait for mask start
		S_MASK  = 10'h008,  // masking pulldown
		S_SHORT = 10'h010,  // wait for short sample
		S_PRES  = 10'h020,  // wait for presence sample
		S_RTAIL = 10'h040,  // rest of reset high time
		S_SLOW  = 10'h080,  // slot low phase
		S_SSAMP = 10'h100,  // wait for slot sample
		S_SREST = 10'h200   // slot recovery
	} seq_state_t;

	seq_state_t       state_reg, state_next;
	swm_pkg::cfg_t    cfg_reg, cfg_next;        // bus_feature_config
	swm_pkg::status_t stat_reg, stat_next;      // bus_status_flags
	swm_pkg::ptr_t    ptr_reg, ptr_next;        // read pointer
	logic [7:0]       rdata_reg, rdata_next;    // read data register
	logic [7:0]       shift_reg, shift_next;    // byte being sent
	logic [2:0]       bit_idx_reg, bit_idx_next;
	logic             byte_mode_reg, byte_mode_next;  // write byte running
	logic             short_reg, short_next;    // short seen this reset
	logic             spu_pend_reg, spu_pend_next;    // strong armed
	logic             apu_arm_reg, apu_arm_next;      // await rising line
	logic             spu_arm_reg, spu_arm_next;      // strong on next rise
	logic             strong_reg, strong_next;        // strong pullup on
	logic             pull_reg, pull_next;            // pulldown drive
	logic             mask_reg, mask_next;            // mask edge slowing
	logic [7:0]       rd_reg, rd_next;                // output byte

	// timer handshakes
	logic                      tmr_load, tmr_done;
	logic [swm_pkg::CNT_W-1:0] tmr_val;
	logic                      apu_load, apu_running;

	logic od;        // overdrive timing in force
	logic bus_cmd;   // command that generates bus traffic
	logic cur_bit;   // bit of the running slot

	// pick standard or overdrive count
	function automatic logic [swm_pkg::CNT_W-1:0] spd(
		input logic                      ovd,
		input logic [swm_pkg::CNT_W-1:0] std_c,
		input logic [swm_pkg::CNT_W-1:0] ovd_c);
		return ovd ? ovd_c : std_c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// phase timer and active pullup on-time timer
	interval_timer #(.WIDTH(swm_pkg::CNT_W)) phase_tmr (
		.clk      (clk),
		.rst      (rst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done),
		.running  ()
	);

	interval_timer #(.WIDTH(swm_pkg::CNT_W)) apu_tmr (
		.clk      (clk),
		.rst      (rst),
		.load     (apu_load),
		.load_val (swm_pkg::APU_ON_CYC),
		.done     (),
		.running  (apu_running)
	);

	assign od      = cfg_reg.overdrive_select;
	assign cur_bit = shift_reg[bit_idx_reg];
	assign bus_cmd = (cmd.op == swm_pkg::OP_BUS_RESET) ||
		(cmd.op == swm_pkg::OP_SINGLE_BIT) ||
		(cmd.op == swm_pkg::OP_WRITE_BYTE);

	////////////////////////////////////////////////////////////////////////////
	// sequencer, registers and command decode
	always_comb begin
		state_next     = state_reg;
		cfg_next       = cfg_reg;
		stat_next      = stat_reg;
		ptr_next       = ptr_reg;
		rdata_next     = rdata_reg;
		shift_next     = shift_reg;
		bit_idx_next   = bit_idx_reg;
		byte_mode_next = byte_mode_reg;
		short_next     = short_reg;
		spu_pend_next  = spu_pend_reg;
		apu_arm_next   = apu_arm_reg;
		spu_arm_next   = spu_arm_reg;
		strong_next    = strong_reg;
		tmr_load       = 1'b0;
		tmr_val        = '0;
		apu_load       = 1'b0;
		cmd_ack        = 1'b0;
		cmd_nack       = 1'b0;

		if (apu_arm_reg && io_in) begin
			apu_load     = 1'b1;
			apu_arm_next = 1'b0;
		end
		if (spu_arm_reg && io_in) begin
			strong_next  = 1'b1;
			spu_arm_next = 1'b0;
		end

		case (state_reg)
			S_IDLE: begin
				// idle: only commands move the sequencer
			end
			S_RLOW: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					if (cfg_reg.presence_mask_enable && !od) begin
						state_next = S_RWAIT;
						tmr_val    = swm_pkg::MASK_START_CYC;
					end else begin
						state_next = S_SHORT;
						tmr_val    = spd(od, swm_pkg::SHORT_STD_CYC,
							swm_pkg::SHORT_OD_CYC);
					end
				end
			end
			S_RWAIT: begin
				if (tmr_done) begin
					state_next = S_MASK;
					tmr_load   = 1'b1;
					tmr_val    = swm_pkg::MASK_LEN_CYC;
				end
			end
			S_MASK: begin
				if (tmr_done) begin
					state_next = S_SHORT;
					tmr_load   = 1'b1;
					tmr_val    = swm_pkg::SHORT_AFTER_MASK_CYC;
				end
			end
			S_SHORT: begin
				if (tmr_done) begin
					short_next = !io_in;
					state_next = S_PRES;
					tmr_load   = 1'b1;
					tmr_val    = spd(od, swm_pkg::PRES_STD_CYC,
						swm_pkg::PRES_OD_CYC);
				end
			end
			S_PRES: begin
				if (tmr_done) begin
					stat_next.short_detect         = short_reg;
					stat_next.presence_detect_flag = !io_in && !short_reg;
					state_next = S_RTAIL;
					tmr_load   = 1'b1;
					tmr_val    = spd(od, swm_pkg::CNT_W'(RESET_HIGH_CYC),
						swm_pkg::RHIGH_OD_CYC);
				end
			end
			S_RTAIL: begin
				if (tmr_done) begin
					state_next               = S_IDLE;
					stat_next.line_busy_flag = 1'b0;
				end
			end
			S_SLOW: begin
				if (tmr_done) begin
					state_next = S_SSAMP;
					tmr_load   = 1'b1;
					tmr_val    = cur_bit ? spd(od, swm_pkg::SAMP_STD_CYC,
						swm_pkg::SAMP_OD_CYC) : swm_pkg::SAMP0_CYC;
					apu_arm_next = cfg_reg.active_pullup_enable;
					if (spu_pend_reg && (!byte_mode_reg ||
						bit_idx_reg == 3'(swm_pkg::LAST_BIT))) begin
						spu_arm_next  = 1'b1;
						apu_arm_next  = 1'b1;
						spu_pend_next = 1'b0;
					end
				end
			end
			S_SSAMP: begin
				if (tmr_done) begin
					shift_next[bit_idx_reg] = io_in;
					if (!byte_mode_reg) begin
						stat_next.single_bit_result = io_in;
					end
					state_next = S_SREST;
					tmr_load   = 1'b1;
					tmr_val    = cur_bit ? spd(od, swm_pkg::REST1_STD_CYC,
						swm_pkg::REST1_OD_CYC) : spd(od,
						swm_pkg::REST0_STD_CYC, swm_pkg::REST0_OD_CYC);
				end
			end
			S_SREST: begin
				if (tmr_done) begin
					if (byte_mode_reg &&
						bit_idx_reg != 3'(swm_pkg::LAST_BIT)) begin
						bit_idx_next = bit_idx_reg + 3'(1);
						state_next   = S_SLOW;
						tmr_load     = 1'b1;
						tmr_val      = shift_reg[bit_idx_reg + 3'(1)] ?
							spd(od, swm_pkg::W1_LOW_STD_CYC,
							swm_pkg::W1_LOW_OD_CYC) : spd(od,
							swm_pkg::W0_LOW_STD_CYC, swm_pkg::W0_LOW_OD_CYC);
					end else begin
						if (byte_mode_reg) begin
							rdata_next = shift_reg;
						end
						state_next               = S_IDLE;
						stat_next.line_busy_flag = 1'b0;
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase

		// commands; device reset and pointer work at any time
		if (cmd_valid) begin
			case (cmd.op)
				swm_pkg::OP_DEV_RESET: begin
					cmd_ack    = 1'b1;
					cfg_next   = swm_pkg::CFG_RESET;
					stat_next  = swm_pkg::STAT_RESET;
					ptr_next   = swm_pkg::PTR_STATUS;
					state_next = S_IDLE;
					tmr_load   = 1'b1;
					tmr_val    = '0;
					spu_pend_next = 1'b0;
					apu_arm_next  = 1'b0;
					spu_arm_next  = 1'b0;
					strong_next   = 1'b0;
				end
				swm_pkg::OP_SET_PTR: begin
					cmd_ack = 1'b1;
					case (cmd.param)
						swm_pkg::PTR_CODE_STATUS: ptr_next = swm_pkg::PTR_STATUS;
						swm_pkg::PTR_CODE_DATA:   ptr_next = swm_pkg::PTR_DATA;
						swm_pkg::PTR_CODE_CONFIG: ptr_next = swm_pkg::PTR_CONFIG;
						default: begin
							cmd_ack  = 1'b0;
							cmd_nack = 1'b1;
						end
					endcase
				end
				swm_pkg::OP_WRITE_CFG: begin
					if (state_reg == S_IDLE &&
						cmd.param[7:4] == ~cmd.param[3:0]) begin
						cmd_ack  = 1'b1;
						cfg_next = swm_pkg::cfg_t'(cmd.param[3:0]);
						stat_next.reset_occurred_flag = 1'b0;
						ptr_next = swm_pkg::PTR_CONFIG;
						if (!cmd.param[2]) begin
							strong_next   = 1'b0;
							spu_arm_next  = 1'b0;
							spu_pend_next = 1'b0;
						end
					end else begin
						cmd_nack = 1'b1;
					end
				end
				default: begin
					if (bus_cmd && state_reg == S_IDLE) begin
						cmd_ack = 1'b1;
						stat_next.line_busy_flag = 1'b1;
						ptr_next   = swm_pkg::PTR_STATUS;
						tmr_load   = 1'b1;
						if (strong_reg) begin
							strong_next                   = 1'b0;
							cfg_next.strong_pullup_enable = 1'b0;
							spu_pend_next                 = 1'b0;
						end else begin
							spu_pend_next = cfg_reg.strong_pullup_enable;
						end
						byte_mode_next = (cmd.op == swm_pkg::OP_WRITE_BYTE);
						bit_idx_next   = '0;
						if (cmd.op == swm_pkg::OP_BUS_RESET) begin
							state_next    = S_RLOW;
							spu_pend_next = 1'b0;
							tmr_val = spd(od, swm_pkg::CNT_W'(RESET_LOW_CYC),
								swm_pkg::RLOW_OD_CYC);
						end else begin
							// single bit sends parameter bit 7
							shift_next = (cmd.op == swm_pkg::OP_WRITE_BYTE) ?
								cmd.param : {8{cmd.param[7]}};
							state_next = S_SLOW;
							tmr_val    = (cmd.op == swm_pkg::OP_WRITE_BYTE ?
								cmd.param[0] : cmd.param[7]) ? spd(od,
								swm_pkg::W1_LOW_STD_CYC, swm_pkg::W1_LOW_OD_CYC)
								: spd(od, swm_pkg::W0_LOW_STD_CYC,
								swm_pkg::W0_LOW_OD_CYC);
						end
					end else begin
						cmd_nack = 1'b1;
					end
				end
			endcase
		end

		// line level only on status read
		if (rd_strobe && ptr_reg == swm_pkg::PTR_STATUS) begin
			stat_next.line_level = io_in;
		end

		// drive derived from the next phase so pins follow state exactly
		pull_next = (state_next == S_RLOW) || (state_next == S_MASK) ||
			(state_next == S_SLOW);
		mask_next = (state_next == S_MASK);

		case (ptr_next)
			swm_pkg::PTR_DATA:   rd_next = rdata_next;
			swm_pkg::PTR_CONFIG: rd_next = {{swm_pkg::NIB_W{1'b0}}, cfg_next};
			default:             rd_next = stat_next;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// register only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg     <= S_IDLE;
			cfg_reg       <= swm_pkg::CFG_RESET;
			stat_reg      <= swm_pkg::STAT_RESET;
			ptr_reg       <= swm_pkg::PTR_STATUS;
			rdata_reg     <= '0;
			shift_reg     <= '0;
			bit_idx_reg   <= '0;
			byte_mode_reg <= 1'b0;
			short_reg     <= 1'b0;
			spu_pend_reg  <= 1'b0;
			apu_arm_reg   <= 1'b0;
			spu_arm_reg   <= 1'b0;
			strong_reg    <= 1'b0;
			pull_reg      <= 1'b0;
			mask_reg      <= 1'b0;
			rd_reg        <= swm_pkg::STAT_RESET;
		end else begin
			state_reg     <= state_next;
			cfg_reg       <= cfg_next;
			stat_reg      <= stat_next;
			ptr_reg       <= ptr_next;
			rdata_reg     <= rdata_next;
			shift_reg     <= shift_next;
			bit_idx_reg   <= bit_idx_next;
			byte_mode_reg <= byte_mode_next;
			short_reg     <= short_next;
			spu_pend_reg  <= spu_pend_next;
			apu_arm_reg   <= apu_arm_next;
			spu_arm_reg   <= spu_arm_next;
			strong_reg    <= strong_next;
			pull_reg      <= pull_next;
			mask_reg      <= mask_next;
			rd_reg        <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins; the line is only ever pulled low, never driven high
	assign io_out          = 1'b0;
	assign io_oe           = pull_reg;
	assign mask_slew_limit = mask_reg;
	assign rd_data         = rd_reg;
	assign pullup_drive    = (apu_running || strong_reg) && !pull_reg;
	assign ext_pullup_ctrl_n = !strong_reg;

endmodule

/* test/single_wire_master_config_status_checker.sv */
// port assertions for the single-wire master block
`timescale 1ns/10ps
module single_wire_master_config_status_checker #(
	parameter int RESET_LOW_CYC  = 4800,
	parameter int RESET_HIGH_CYC = 4100
) (
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          cmd_valid,
	input wire swm_pkg::cmd_t cmd,
	input wire logic          cmd_ack,
	input wire logic          cmd_nack,
	input wire logic [7:0]    rd_data,
	input wire logic          io_out,
	input wire logic          io_oe,
	input wire logic          pullup_drive,
	input wire logic          mask_slew_limit,
	input wire logic          ext_pullup_ctrl_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic take;  // command accepted this cycle
	assign take = cmd_valid & cmd_ack;
	AST_ONE_ANSWER: assert property (cmd_valid |-> cmd_ack ^ cmd_nack)
		else $error("ack and nack disagree");
	AST_CFG_CHECK: assert property (
		cmd_valid && cmd.op == swm_pkg::OP_WRITE_CFG &&
		cmd.param[7:4] != ~cmd.param[3:0] |-> cmd_nack)
		else $error("bad config write taken");
	AST_CFG_UPPER: assert property (
		take && cmd.op == swm_pkg::OP_SET_PTR && cmd.param == 8'hc3
		|=> rd_data[7:4] == 4'h0)
		else $error("upper config nibble not zero");
	AST_DEV_RESET: assert property (
		cmd_valid && cmd.op == swm_pkg::OP_DEV_RESET
		|-> cmd_ack ##1 (rd_data == 8'h10 && ext_pullup_ctrl_n))
		else $error("device reset result wrong");
	AST_BUSY: assert property (
		take && cmd.op inside {swm_pkg::OP_BUS_RESET,
		swm_pkg::OP_SINGLE_BIT, swm_pkg::OP_WRITE_BYTE} |=> rd_data[0])
		else $error("busy not shown after bus command");
	AST_MASK_DRIVE: assert property (mask_slew_limit |-> io_oe)
		else $error("mask without pulldown");
	AST_PULL_EXCL: assert property (io_oe |-> !pullup_drive)
		else $error("pullup while pulling low");
	AST_STRONG_EXT: assert property (!ext_pullup_ctrl_n |-> pullup_drive)
		else $error("external pullup without strong pullup");
	// the line is open drain: only pullups may ever lift it
	AST_OPEN_DRAIN: assert property (io_out == 1'b0)
		else $error("line driven high");
	// plain active pullup lasts its on-time of 25 cycles, then lets go
	AST_APU_TIME: assert property (
		$rose(pullup_drive) && ext_pullup_ctrl_n
		|-> ##24 (pullup_drive || io_oe) ##1 !pullup_drive)
		else $error("active pullup on-time wrong");
endmodule
bind single_wire_master_config_status single_wire_master_config_status_checker
	#(.RESET_LOW_CYC(RESET_LOW_CYC), .RESET_HIGH_CYC(RESET_HIGH_CYC)) chk (.*);

/* test/swm_slave_model.sv */
// slave on the wire: presence answer after a long low, optional short
`timescale 1ns/10ps
module swm_slave_model (
	input  wire logic clk,
	input  wire logic io_oe,     // master pulling low
	input  wire logic short_en,  // line shorted to ground
	output logic      io_line    // pulled-up line level
);
	int low_cnt  = 0;  // length of master low
	int pres_cnt = 0;  // time since long low ended
	// presence answer, 30us to 150us after release
	always @(posedge clk) begin
		low_cnt <= io_oe ? low_cnt + 1 : 0;
		if (!io_oe && low_cnt > 2000)
			pres_cnt <= 1;
		else if (pres_cnt != 0 && pres_cnt < 1500)
			pres_cnt <= pres_cnt + 1;
		else
			pres_cnt <= 0;
	end
	// wired-and with pull-up
	assign io_line = !(io_oe || short_en || pres_cnt >= 300);
endmodule

/* test/single_wire_master_config_status_test.sv */
// random and corner tests of the master configuration and status
`timescale 1ns/10ps
module single_wire_master_config_status_test;
	logic          clk = 0, rst = 1, cmd_valid = 0, short_en = 0;
	logic          rd_strobe = 0;      // host read pulse
	swm_pkg::cmd_t cmd = '0;
	logic          cmd_ack, cmd_nack, io_in, io_oe, ext_n, pud, msk;
	logic [7:0]    rd_data, b;
	logic [31:0]   lf = 32'hbc69c2b5;  // random state
	logic [3:0]    cfg = 4'h0;         // expected configuration
	int            n_mismatch = 0, tests_run = 0, i;
	initial forever #50 clk = ~clk;
	single_wire_master_config_status dut (.clk(clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ack(cmd_ack),
		.cmd_nack(cmd_nack), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.io_in(io_in), .io_out(), .io_oe(io_oe), .pullup_drive(pud),
		.mask_slew_limit(msk), .ext_pullup_ctrl_n(ext_n));
	swm_slave_model slv (.clk(clk), .io_oe(io_oe), .short_en(short_en),
		.io_line(io_in));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one command, ack checked in its cycle
	task automatic send(input swm_pkg::op_t op, input logic [7:0] p, input logic ak);
		@(posedge clk) #1;
		cmd_valid = 1;
		cmd = '{op, p};
		#1 chk("ack", {7'h0, ak}, {7'h0, cmd_ack});
		@(posedge clk) #1;
		cmd_valid = 0;
	endtask
	task automatic wait_idle;
		for (i = 0; i < 20000 && rd_data[0] !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 20000) begin
			n_mismatch++;
			close_out;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 0;
		chk("status", 8'h10, rd_data);
		send(swm_pkg::OP_SET_PTR, 8'hc3, 1'b1);
		chk("cfg", 8'h00, rd_data);
		send(swm_pkg::OP_SET_PTR, 8'h5a, 1'b0);
		send(swm_pkg::OP_SET_PTR, 8'hf0, 1'b1);
		chk("ptr", 8'h10, rd_data);
		send(swm_pkg::OP_SET_PTR, 8'he1, 1'b1);
		for (int k = 0; k < 24; k++) begin
			lf = nxt(lf);
			b = k[0] ? {~lf[3:0], lf[3:0]} : lf[7:0];
			send(swm_pkg::OP_WRITE_CFG, b, b[7:4] === ~b[3:0]);
			if (b[7:4] === ~b[3:0]) cfg = b[3:0];
			send(swm_pkg::OP_SET_PTR, 8'hc3, 1'b1);
			chk("cfg", {4'h0, cfg}, rd_data);
		end
		$display("config test done");
		send(swm_pkg::OP_WRITE_CFG, 8'hd2, 1'b1);
		send(swm_pkg::OP_BUS_RESET, 8'h00, 1'b1);
		wait_idle;
		chk("presence", 8'h02, rd_data & 8'h06);
		short_en = 1;
		send(swm_pkg::OP_BUS_RESET, 8'h00, 1'b1);
		wait_idle;
		chk("short", 8'h04, rd_data & 8'h06);
		// line level follows the wire only on a status read
		@(posedge clk) #1 rd_strobe = 1;
		@(posedge clk) #1 rd_strobe = 0;
		chk("level", 8'h00, rd_data & 8'h08);
		short_en = 0;
		@(posedge clk) #1 rd_strobe = 1;
		@(posedge clk) #1 rd_strobe = 0;
		chk("level", 8'h08, rd_data & 8'h08);
		$display("bus reset test done");
		// strong armed just before the bit
		send(swm_pkg::OP_WRITE_CFG, 8'ha5, 1'b1);
		send(swm_pkg::OP_SINGLE_BIT, 8'h80, 1'b1);
		wait_idle;
		chk("slot", 8'h01, {7'h0, i <= 650});
		chk("pullup", 8'h01, {7'h0, pud});
		chk("ext on", 8'h00, {7'h0, ext_n});
		send(swm_pkg::OP_BUS_RESET, 8'h00, 1'b1);
		chk("ext off", 8'h01, {7'h0, ext_n});
		wait_idle;
		send(swm_pkg::OP_SET_PTR, 8'hc3, 1'b1);
		chk("cfg", 8'h01, rd_data);
		send(swm_pkg::OP_WRITE_CFG, 8'ha5, 1'b1);
		send(swm_pkg::OP_SINGLE_BIT, 8'h80, 1'b1);
		wait_idle;
		send(swm_pkg::OP_WRITE_CFG, 8'he1, 1'b1);
		chk("ext off", 8'h01, {7'h0, ext_n});
		send(swm_pkg::OP_DEV_RESET, 8'h00, 1'b1);
		chk("status", 8'h10, rd_data);
		send(swm_pkg::OP_SET_PTR, 8'hc3, 1'b1);
		chk("cfg", 8'h00, rd_data);
		$display("strong test done");
		// byte command, overdrive right after it, then back to standard
		send(swm_pkg::OP_WRITE_BYTE, 8'hff, 1'b1);
		wait_idle;
		send(swm_pkg::OP_WRITE_CFG, 8'h69, 1'b1);
		send(swm_pkg::OP_SINGLE_BIT, 8'h80, 1'b1);
		wait_idle;
		chk("od slot", 8'h01, {7'h0, i <= 100});
		chk("bit", 8'h20, rd_data & 8'h21);
		send(swm_pkg::OP_SET_PTR, 8'he1, 1'b1);
		chk("rdata", 8'hff, rd_data);
		send(swm_pkg::OP_WRITE_CFG, 8'hf0, 1'b1);
		send(swm_pkg::OP_BUS_RESET, 8'h00, 1'b1);
		wait_idle;
		chk("presence", 8'h02, rd_data & 8'h06);
		$display("speed test done");
		close_out;
	end
endmodule
